// >>> include/sdio_flags_defs.svh
// Purpose: offsets, bit positions, reset values and counts of the flag block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef SDIO_FLAGS_DEFS_SVH
`define SDIO_FLAGS_DEFS_SVH

// register byte offsets
`define OFS_TRANSFER_STATUS 8'h34
`define OFS_FLAG_CLEAR      8'h38
`define OFS_IRQ_MASK        8'h3c

// reset values
`define RST_STATUS 24'h000000
`define RST_MASK   24'h000000

// flag bit positions
`define FLG_ATA_DONE    23
`define FLG_CARD_IRQ    22
`define FLG_RX_HAS_DATA 21
`define FLG_TX_HAS_DATA 20
`define FLG_RX_EMPTY    19
`define FLG_TX_EMPTY    18
`define FLG_RX_FULL     17
`define FLG_TX_FULL     16
`define FLG_RX_HALF     15
`define FLG_TX_HALF     14
`define FLG_RX_BUSY     13
`define FLG_TX_BUSY     12
`define FLG_CMD_BUSY    11
`define FLG_BLOCK_DONE  10
`define FLG_START_ERR   9
`define FLG_XFER_DONE   8
`define FLG_CMD_ISSUED  7
`define FLG_RESP_OK     6
`define FLG_RX_OVERRUN  5
`define FLG_TX_UNDERRUN 4
`define FLG_DATA_TMO    3
`define FLG_RESP_TMO    2
`define FLG_DATA_CRC    1
`define FLG_RESP_CRC    0

// sticky positions 23:22 and 10:0
`define STICKY_BITS 24'hc007ff

// fifo thresholds in words, timeout in card clock periods
`define FIFO_DEPTH_WORDS 32
`define FIFO_HALF_WORDS  8
`define FLOW_CTRL_MARGIN 2
`define RESP_TMO_TICKS   64

`endif

// >>> include/sdio_flags_pkg.sv
// Purpose: carrier types of the flag block
// Assumes: nothing
// Notes:   one-cycle pulses in evt_t, levels in act_t
package sdio_flags_pkg;

   // event pulses from the command and data paths
   typedef struct packed {
      logic ata_cmd_done;
      logic card_irq;
      logic block_done;
      logic start_bit_error;
      logic transfer_done;
      logic cmd_issued;
      logic resp_ok;
      logic rx_overrun;
      logic tx_underrun;
      logic data_timeout;
      logic data_crc_error;
      logic resp_crc_error;
   } evt_t;

   // activity levels
   typedef struct packed {
      logic rx_busy;
      logic tx_busy;
      logic cmd_busy;
   } act_t;

endpackage : sdio_flags_pkg

// >>> logic/sdio_status_irq_flags.sv
// Purpose: status flags, flag clear, interrupt mask and request
// Assumes: sources run on clk_i; card_tick_i pulses once per card clock
// Notes:   read data one cycle after the read strobe
`timescale 1ns/1ns
`include "sdio_flags_defs.svh"

// Behaviour
// - bits 23:22,10:0 stay set until cleared
// - bits 21:11 follow live fifo/activity state
// - status read-only, bits 31:24 read zero
// - bit 23 set on ata completion
// - bit 22 set on card interrupt
// - bits 21/20 rx/tx fifo hold data
// - bit 18 tx empty, 2 words with flow control
// - bit 17 rx full, 2 early with flow control
// - bit 15 when rx holds eight or more
// - bit 14 when tx room eight or more
// - bit 19 rx empty, bit 16 tx full
// - bits 13..11 high while activity runs
// - bit 10 set on good block
// - bit 9 set on start bit error
// - bit 8 set when data counter zero
// - bit 7 set when command sent, no response
// - bit 6 set on good response
// - bit 5 overrun, bit 4 underrun
// - bit 3 data timeout, bit 2 after 64 ticks
// - bit 1 data crc, bit 0 response crc
// - clear register write-one-clears, reserved ignored
// - mask bit one lets flag request interrupt
module sdio_status_irq_flags #(
   parameter int DEPTH = `FIFO_DEPTH_WORDS,
   parameter int LW    = $clog2(DEPTH + 1)
) (
   // clock, reset, enable
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  ce_i,
   // register port
   input  wire logic [7:0]            addr_i,
   input  wire logic [31:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [31:0]           rdata_o,
   // flag sources
   input  wire sdio_flags_pkg::evt_t  evt_i,
   input  wire sdio_flags_pkg::act_t  act_i,
   input  wire logic [LW-1:0]         rx_level_i,
   input  wire logic [LW-1:0]         tx_level_i,
   input  wire logic                  flow_ctrl_en_i,
   // response timeout timing
   input  wire logic                  resp_wait_i,
   input  wire logic                  card_tick_i,
   // interrupt request
   output logic                       irq_o
);

   // thresholds at level width
   localparam logic [LW-1:0] HALF_W  = LW'(`FIFO_HALF_WORDS);
   localparam logic [LW-1:0] FULL_W  = LW'(DEPTH);
   localparam logic [LW-1:0] FC_W    = LW'(`FLOW_CTRL_MARGIN);
   localparam logic [LW-1:0] FC_FULL = LW'(DEPTH - `FLOW_CTRL_MARGIN);
   localparam logic [6:0]    TMO_END = 7'(`RESP_TMO_TICKS);

   // level comparison shared by several flags
   function automatic logic at_least(input logic [LW-1:0] lvl,
                                     input logic [LW-1:0] thr);
      at_least = (lvl >= thr);
   endfunction : at_least

   // state
   logic [23:0] sticky_r;
   logic [23:0] sticky_nxt;
   logic [23:0] mask_r;
   logic [23:0] mask_nxt;
   logic [31:0] rdata_nxt;
   logic        irq_nxt;
   logic [6:0]  tmo_cnt_r;
   logic [6:0]  tmo_cnt_nxt;

   // decode and flags
   logic [23:0] set_w;
   logic [23:0] dyn_w;
   logic [23:0] status_w;
   logic [23:0] clr_w;
   logic        hit_status_w;
   logic        hit_clear_w;
   logic        hit_mask_w;
   logic        clr_wr_w;
   logic        mask_wr_w;
   logic        tmo_hit_w;
   logic [LW-1:0] tx_room_w;

   // address decode
   assign hit_status_w = (addr_i == `OFS_TRANSFER_STATUS);
   assign hit_clear_w  = (addr_i == `OFS_FLAG_CLEAR);
   assign hit_mask_w   = (addr_i == `OFS_IRQ_MASK);
   assign clr_wr_w     = wr_i && hit_clear_w;
   assign mask_wr_w    = wr_i && hit_mask_w;

   // reserved clear positions
   // only sticky positions can be cleared
   assign clr_w = clr_wr_w ? (wdata_i[23:0] & `STICKY_BITS) : 24'h000000;

   // response timeout counter, counts card ticks while waiting
   // fixed 64 ticks
   assign tmo_hit_w = resp_wait_i && card_tick_i && (tmo_cnt_r == TMO_END - 7'h01);
   assign tmo_cnt_nxt = !resp_wait_i ? 7'h00 :
                        (card_tick_i && tmo_cnt_r != TMO_END) ? tmo_cnt_r + 7'h01 :
                        tmo_cnt_r;

   // hardware set events into sticky positions
   always_comb begin
      set_w = 24'h000000;
      set_w[`FLG_ATA_DONE]    = evt_i.ata_cmd_done;
      set_w[`FLG_CARD_IRQ]    = evt_i.card_irq;
      set_w[`FLG_BLOCK_DONE]  = evt_i.block_done;
      set_w[`FLG_START_ERR]   = evt_i.start_bit_error;
      set_w[`FLG_XFER_DONE]   = evt_i.transfer_done;
      set_w[`FLG_CMD_ISSUED]  = evt_i.cmd_issued;
      set_w[`FLG_RESP_OK]     = evt_i.resp_ok;
      set_w[`FLG_RX_OVERRUN]  = evt_i.rx_overrun;
      set_w[`FLG_TX_UNDERRUN] = evt_i.tx_underrun;
      set_w[`FLG_DATA_TMO]    = evt_i.data_timeout;
      set_w[`FLG_RESP_TMO]    = tmo_hit_w;
      set_w[`FLG_DATA_CRC]    = evt_i.data_crc_error;
      set_w[`FLG_RESP_CRC]    = evt_i.resp_crc_error;
   end

   // live flags, never latched
   assign tx_room_w = FULL_W - tx_level_i;
   always_comb begin
      dyn_w = 24'h000000;
      dyn_w[`FLG_RX_HAS_DATA] = (rx_level_i != '0);
      dyn_w[`FLG_TX_HAS_DATA] = (tx_level_i != '0);
      dyn_w[`FLG_RX_EMPTY]    = (rx_level_i == '0);
      dyn_w[`FLG_TX_FULL]     = at_least(tx_level_i, FULL_W);
      // tx empty early under flow control
      dyn_w[`FLG_TX_EMPTY]    = flow_ctrl_en_i ? !at_least(tx_level_i, FC_W + 1'b1)
                                               : (tx_level_i == '0);
      // rx full early under flow control
      dyn_w[`FLG_RX_FULL]     = flow_ctrl_en_i ? at_least(rx_level_i, FC_FULL)
                                               : at_least(rx_level_i, FULL_W);
      dyn_w[`FLG_RX_HALF]     = at_least(rx_level_i, HALF_W);
      dyn_w[`FLG_TX_HALF]     = at_least(tx_room_w, HALF_W);
      dyn_w[`FLG_RX_BUSY]     = act_i.rx_busy;
      dyn_w[`FLG_TX_BUSY]     = act_i.tx_busy;
      dyn_w[`FLG_CMD_BUSY]    = act_i.cmd_busy;
   end

   // live bits merged
   // combined status word
   assign status_w = (sticky_r & `STICKY_BITS) | (dyn_w & ~`STICKY_BITS);

   assign sticky_nxt = ((sticky_r & ~clr_w) | set_w) & `STICKY_BITS;

   assign mask_nxt = mask_wr_w ? wdata_i[23:0] : mask_r;

   // request is or of gated flags
   assign irq_nxt = |(status_w & mask_r);

   // read-only status, upper bits zero
   // clear register and unmapped offsets read zero
   assign rdata_nxt = !rd_i         ? 32'h00000000 :
                      hit_status_w  ? {8'h00, status_w} :
                      hit_mask_w    ? {8'h00, mask_r} :
                      32'h00000000;

   // flag and mask state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sticky_r <= `RST_STATUS;
         mask_r   <= `RST_MASK;
      end else if (ce_i) begin
         sticky_r <= sticky_nxt;
         mask_r   <= mask_nxt;
      end
   end

   // timeout counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmo_cnt_r <= 7'h00;
      end else if (ce_i) begin
         tmo_cnt_r <= tmo_cnt_nxt;
      end
   end

   // registered outputs; irq lags flags one cycle for a clean output
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h00000000;
         irq_o   <= 1'b0;
      end else if (ce_i) begin
         rdata_o <= rdata_nxt;
         irq_o   <= irq_nxt;
      end
   end

   // checks

   a_sticky_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($past(ce_i) && !$past(clr_wr_w)) |-> ((sticky_r & $past(sticky_r)) == $past(sticky_r)))
      else $error("sticky flag dropped without clear");

   a_live_rx_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[`FLG_RX_BUSY] == $past(act_i.rx_busy)))
      else $error("rx busy not live in status read");

   a_status_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[31:24] == 8'h00))
      else $error("status upper bits not zero");

   a_tx_empty_fc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (flow_ctrl_en_i && tx_level_i == FC_W) |-> status_w[`FLG_TX_EMPTY])
      else $error("tx empty not set at two words");

   a_rx_full_fc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (flow_ctrl_en_i && rx_level_i == FC_FULL - 1'b1) |-> !status_w[`FLG_RX_FULL])
      else $error("rx full set too early");

   a_rx_half_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rx_level_i == HALF_W - 1'b1) |-> !status_w[`FLG_RX_HALF])
      else $error("rx half full below eight words");

   a_resp_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && resp_wait_i && card_tick_i && tmo_cnt_r == 7'h3f) |=> sticky_r[`FLG_RESP_TMO])
      else $error("response timeout not flagged");

   a_clear_works: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(ce_i && clr_wr_w) |-> ((sticky_r & $past(clr_w & ~set_w)) == 24'h000000))
      else $error("flag not cleared by write one");

   a_mask_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && mask_wr_w) |=> (mask_r == $past(wdata_i[23:0])))
      else $error("mask write lost");

   a_irq_or: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i |=> (irq_o == $past(|(status_w & mask_r))))
      else $error("interrupt request wrong");

   a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(ce_i) |-> ((sticky_r & $past(set_w)) == $past(set_w)))
      else $error("set event lost");

   a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !rd_i) |=> (rdata_o == 32'h00000000))
      else $error("read data not zero outside read");

   a_ata_done_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.ata_cmd_done) |=> sticky_r[`FLG_ATA_DONE])
      else $error("ata completion flag not set");

   a_card_irq_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.card_irq) |=> sticky_r[`FLG_CARD_IRQ])
      else $error("card interrupt flag not set");

   a_rx_data_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w && rx_level_i != '0) |=> rdata_o[`FLG_RX_HAS_DATA])
      else $error("rx data present not shown");

   a_tx_data_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w && tx_level_i != '0) |=> rdata_o[`FLG_TX_HAS_DATA])
      else $error("tx data present not shown");

   a_tx_half_room: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tx_level_i == FULL_W - HALF_W) |-> status_w[`FLG_TX_HALF])
      else $error("tx half empty missing at eight free");

   a_rx_empty_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[`FLG_RX_EMPTY] == ($past(rx_level_i) == '0)))
      else $error("rx empty flag wrong");

   a_tx_full_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[`FLG_TX_FULL] == ($past(tx_level_i) == FULL_W)))
      else $error("tx full flag wrong");

   a_tx_busy_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[`FLG_TX_BUSY] == $past(act_i.tx_busy)))
      else $error("tx busy not live in status read");

   a_cmd_busy_live: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && hit_status_w) |=> (rdata_o[`FLG_CMD_BUSY] == $past(act_i.cmd_busy)))
      else $error("command busy not live in status read");

   a_block_done_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.block_done) |=> sticky_r[`FLG_BLOCK_DONE])
      else $error("block done flag not set");

   a_start_err_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.start_bit_error) |=> sticky_r[`FLG_START_ERR])
      else $error("start bit error flag not set");

   a_xfer_done_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.transfer_done) |=> sticky_r[`FLG_XFER_DONE])
      else $error("transfer done flag not set");

   a_cmd_issued_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.cmd_issued) |=> sticky_r[`FLG_CMD_ISSUED])
      else $error("command sent flag not set");

   a_resp_ok_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.resp_ok) |=> sticky_r[`FLG_RESP_OK])
      else $error("response ok flag not set");

   a_overrun_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.rx_overrun) |=> sticky_r[`FLG_RX_OVERRUN])
      else $error("rx overrun flag not set");

   a_underrun_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.tx_underrun) |=> sticky_r[`FLG_TX_UNDERRUN])
      else $error("tx underrun flag not set");

   a_data_tmo_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.data_timeout) |=> sticky_r[`FLG_DATA_TMO])
      else $error("data timeout flag not set");

   a_data_crc_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.data_crc_error) |=> sticky_r[`FLG_DATA_CRC])
      else $error("data crc flag not set");

   a_resp_crc_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && evt_i.resp_crc_error) |=> sticky_r[`FLG_RESP_CRC])
      else $error("response crc flag not set");

endmodule : sdio_status_irq_flags

// >>> verification/sdio_path_model.sv
// Purpose: stand-in for the command and data path state machines
// Assumes: one clock; every change lands just after a rising edge
// Notes:   events are one-cycle pulses; card ticks come only while a response is awaited
`timescale 1ns/1ns
module sdio_path_model (
   // clock
   input  wire logic            clk_i,
   // flag sources
   output sdio_flags_pkg::evt_t evt_o,
   output sdio_flags_pkg::act_t act_o,
   output logic [5:0]           rx_level_o,
   output logic [5:0]           tx_level_o,
   output logic                 flow_ctrl_en_o,
   output logic                 resp_wait_o,
   output logic                 card_tick_o
);
   // quiet path at time zero
   initial begin
      evt_o = '0;
      act_o = '0;
      rx_level_o = '0;
      tx_level_o = '0;
      flow_ctrl_en_o = 1'b0;
      resp_wait_o = 1'b0;
      card_tick_o = 1'b0;
   end

   // one-cycle pulse, never held, so a flag can only be set once per call
   task automatic fire(input logic [11:0] m);
      @(posedge clk_i);
      evt_o <= sdio_flags_pkg::evt_t'(m);
      @(posedge clk_i);
      evt_o <= '0;
   endtask : fire

   // fifo levels and activity as the data path would show them
   task automatic set_lv(input logic [5:0] r, input logic [5:0] t, input logic f, input logic [2:0] a);
      @(posedge clk_i);
      rx_level_o <= r;
      tx_level_o <= t;
      flow_ctrl_en_o <= f;
      act_o <= sdio_flags_pkg::act_t'(a);
   endtask : set_lv

   // card clock pacing
   // slow card: one tick every other bus cycle while waiting
   task automatic ticks(input int n);
      resp_wait_o <= 1'b1;
      repeat (n) begin
         @(posedge clk_i);
         card_tick_o <= 1'b1;
         @(posedge clk_i);
         card_tick_o <= 1'b0;
      end
   endtask : ticks

   // response wait over
   task automatic wait_end();
      @(posedge clk_i);
      resp_wait_o <= 1'b0;
   endtask : wait_end
endmodule : sdio_path_model

// >>> verification/sdio_status_irq_flags_tb.sv
// Purpose: self-checking bench of the status, clear and mask block
// Assumes: bus master changes strobes right after rising edges
// Notes:   expected status built from a sticky model and the live levels
`timescale 1ns/1ns
module sdio_status_irq_flags_tb;
   logic clk_i, rst_n_i, ce_i, wr_i, rd_i, irq_o, fc, rw, tk;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [5:0] rxl, txl, rl, tl;
   logic [2:0] act;
   logic [23:0] sk;
   sdio_flags_pkg::evt_t ev;
   sdio_flags_pkg::act_t ac;
   logic fce;
   int n_fail, checked;

   sdio_status_irq_flags #(.DEPTH(32)) sdio_status_irq_flags_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(ev), .act_i(ac),
      .rx_level_i(rl), .tx_level_i(tl), .flow_ctrl_en_i(fce), .resp_wait_i(rw), .card_tick_i(tk), .irq_o(irq_o));
   sdio_path_model sdio_path_model_i (.clk_i(clk_i), .evt_o(ev), .act_o(ac), .rx_level_o(rl), .tx_level_o(tl),
      .flow_ctrl_en_o(fce), .resp_wait_o(rw), .card_tick_o(tk));

   // 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask : rchk

   // irq is registered behind status, so give it two edges
   task automatic ichk(input logic e);
      repeat (2) @(posedge clk_i);
      #1 chk({31'h0, irq_o}, {31'h0, e});
   endtask : ichk

   function automatic logic [31:0] estat();
      logic [23:0] v;
      v = sk;
      v[21] = rxl != 0;
      v[20] = txl != 0;
      v[19] = rxl == 0;
      v[18] = fc ? txl <= 2 : txl == 0;
      v[17] = fc ? rxl >= 30 : rxl == 32;
      v[16] = txl == 32;
      v[15] = rxl >= 8;
      v[14] = txl <= 24;
      v[13:11] = act;
      return {8'h00, v};
   endfunction : estat

   task automatic lv(input logic [5:0] r, input logic [5:0] t, input logic f, input logic [2:0] a);
      sdio_path_model_i.set_lv(r, t, f, a);
      rxl = r;
      txl = t;
      fc = f;
      act = a;
   endtask : lv

   task automatic t_reset();
      rchk(8'h34, estat());
      rchk(8'h3c, 32'h0);
      rchk(8'h38, 32'h0);
      rchk(8'h40, 32'h0);
      $display("reset values done");
   endtask : t_reset

   task automatic t_sticky();
      int p;
      for (int i = 0; i < 12; i++) begin
         p = (i >= 10) ? i + 12 : ((i >= 2) ? i + 1 : i);
         sdio_path_model_i.fire(12'h001 << i);
         sk[p] = 1'b1;
         rchk(8'h34, estat());
         wr(8'h38, 32'h0);
         wr(8'h34, 32'hffffffff);
         rchk(8'h34, estat());
         wr(8'h38, 32'hff3ff800 | (32'h1 << p));
         sk[p] = 1'b0;
         rchk(8'h34, estat());
      end
      $display("sticky flags done");
   endtask : t_sticky

   task automatic t_live();
      logic [5:0] rt[7] = '{6'h00, 6'h01, 6'h08, 6'h1e, 6'h1d, 6'h20, 6'h07};
      logic [5:0] tt[7] = '{6'h00, 6'h20, 6'h18, 6'h02, 6'h03, 6'h19, 6'h1f};
      logic ft[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      logic [2:0] at[7] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h4, 3'h0, 3'h3};
      for (int i = 0; i < 7; i++) begin
         lv(rt[i], tt[i], ft[i], at[i]);
         rchk(8'h34, estat());
      end
      lv(6'h00, 6'h00, 1'b0, 3'h0);
      $display("live flags done");
   endtask : t_live

   task automatic t_timeout();
      sdio_path_model_i.ticks(63);
      rchk(8'h34, estat());
      sdio_path_model_i.ticks(1);
      sk[2] = 1'b1;
      rchk(8'h34, estat());
      sdio_path_model_i.wait_end();
      wr(8'h38, 32'h4);
      sk[2] = 1'b0;
      rchk(8'h34, estat());
      $display("response timeout done");
   endtask : t_timeout

   task automatic t_irq();
      wr(8'h3c, 32'hffffffff);
      rchk(8'h3c, 32'h00ffffff);
      ichk(1'b1);
      wr(8'h3c, 32'h0000003f);
      ichk(1'b0);
      sdio_path_model_i.fire(12'h020);
      sk[6] = 1'b1;
      ichk(1'b0);
      wr(8'h3c, 32'h00000040);
      ichk(1'b1);
      fork
         sdio_path_model_i.fire(12'h020);
         wr(8'h38, 32'h40);
      join
      rchk(8'h34, estat());
      wr(8'h38, 32'h40);
      sk[6] = 1'b0;
      ichk(1'b0);
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(8'h3c, 32'h00080000);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rchk(8'h3c, 32'h00000040);
      wr(8'h3c, 32'h00080000);
      ichk(1'b1);
      wr(8'h3c, 32'h0);
      $display("mask and request done");
   endtask : t_irq

   task automatic results();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results

   // main sequence
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      n_fail = 0;
      checked = 0;
      sk = '0;
      rxl = '0;
      txl = '0;
      fc = 1'b0;
      act = '0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_sticky();
      t_live();
      t_timeout();
      t_irq();
      results();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #500000;
      n_fail++;
      results();
   end
endmodule : sdio_status_irq_flags_tb
